// File: logic/cfpe_pkg.sv
// Shared constants and state codes of the frame protocol engine
`default_nettype none
package cfpe_pkg;
   // Bus levels: dominant overrides recessive on the wire
   localparam logic DOM = 1'b0;
   localparam logic REC = 1'b1;

   // Bit counts of the fixed fields, in bit times
   localparam logic [2:0] STUFF_RUN  = 3'h5;  // Equal bits before a stuff bit
   localparam logic [2:0] FLAG_BITS  = 3'h6;  // Error or overload flag
   localparam logic [3:0] EOF_BITS   = 4'h7;  // End of frame
   localparam logic [3:0] INTER_BITS = 4'h3;  // Intermission
   localparam logic [3:0] SUSP_BITS  = 4'h8;  // Suspend transmission
   localparam logic [3:0] DELIM_BITS = 4'h8;  // Error or overload delimiter
   localparam logic [3:0] SOF_SLOT   = 4'h2;  // Intermission bit read as SOF
   localparam logic [3:0] TX_EARLY   = 4'h1;  // Bit after which SOF is driven

   // Reset values of the engine
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [2:0] RUN_RST = 3'h0;

   // Protocol states, one per field of the frame or the bus
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_FRAME   = 4'b0001,
      ST_CRC_DEL = 4'b0010,
      ST_ACK     = 4'b0011,
      ST_ACK_DEL = 4'b0100,
      ST_EOF     = 4'b0101,
      ST_INTER   = 4'b0110,
      ST_SUSPEND = 4'b0111,
      ST_FLAG    = 4'b1000,
      ST_FLAGW   = 4'b1001,
      ST_DELIM   = 4'b1010,
      ST_SLEEP   = 4'b1011,
      ST_STOP    = 4'b1100
   } cfpe_state_e;
endpackage
`default_nettype wire

// File: logic/cfpe_engine.sv
// Bit-level protocol engine: fields, stuffing, arbitration, errors
// Summary of operation
// [RQ1] Receiver drives ACK slot dominant unless an error was found.
// [RQ2] Transmitter sends ACK slot and delimiter recessive, watches the bus.
// [RQ3] Every data or remote frame ends with seven recessive bits.
// [RQ4] An interframe space follows every frame of any kind.
// [RQ5] Error active: intermission then idle, pending sender may start.
// [RQ6] Error passive sender: eight suspend bits; another SOF makes receiver.
// [RQ7] Dominant third intermission bit is SOF: receive, or send identifier.
// [RQ8] Passive error flag ends only after six equal bits seen.
// [RQ9] Dominant after six recessive flag bits: end at next recessive.
// [RQ10] Receiver not ready starts overload at first intermission bit.
// [RQ11] Dominant in intermission starts overload on the following bit.
// [RQ12] First node driving SOF in idle transmits; others receive.
// [RQ13] Transmitter loses arbitration on mismatch, recessive from next bit.
// [RQ14] Longest dominant run wins; data beats remote frame.
// [RQ15] Transmitter inserts opposite bit after five equal bits.
// [RQ16] Receiver discards bit after five equal bits.
// [RQ17] Sleep wakes on bus activity; stop leaves only by processor access.
// [RQ18] Bit error when driven level differs from bus, stuff bits excluded.
// [RQ19] Stuff error on six equal bits in the stuffed region.
// [RQ20] Receiver flags CRC error when the received CRC disagrees.
// [RQ21] Form error on an inverted fixed-format bit.
// [RQ22] Transmitter flags ACK error on recessive ACK slot.
// [RQ23] Logic 0 is dominant, logic 1 recessive; dominant wins.
// [RQ24] Error frame next bit; for CRC error after the ACK delimiter.
// [RQ25] Active error flag six dominant bits; passive six recessive.
`default_nettype none
module cfpe_engine #(
   parameter int DEPTH = 2,
   parameter int W     = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         bit_tick,
   input  wire logic         rx_pin,
   output var  logic         tx_pin,
   input  wire logic         tx_req,
   input  wire logic         tx_bit,
   output logic              tx_take,
   input  wire logic         fr_arb,
   input  wire logic         fr_crc_last,
   input  wire logic         fr_crc_ok,
   input  wire logic         err_passive,
   input  wire logic         host_busy,
   input  wire logic         sleep_req,
   input  wire logic         stop_req,
   input  wire logic         cpu_access,
   output logic              bit_done,
   output logic              rx_valid,
   input  wire logic         rx_ready,
   output logic [W-1:0]      rx_data,
   output logic              is_transmitter,
   output logic              bus_idle,
   output logic              sleeping,
   output logic              stopped,
   output var  logic         arb_lost,
   output var  logic         frame_ok,
   output var  logic         err_bit,
   output var  logic         err_stuff,
   output var  logic         err_crc,
   output var  logic         err_form,
   output var  logic         err_ack,
   output var  logic         wake_evt,
   output var  logic         rx_overrun
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Refuse buffer shapes the pointer logic cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
   begin : g_chk
      $error("cfpe_engine: DEPTH must be a power of two >= 2, W >= 1");
   end

   cfpe_pkg::cfpe_state_e st_q;
   logic                  rx_m_q;
   logic                  rx_s_q;
   logic                  tx_q;
   logic [2:0]            run_q;
   logic                  last_q;
   logic [3:0]            cnt_q;
   logic                  txing_q;
   logic                  susp_q;
   logic                  crc_err_q;
   logic                  ovl_q;
   logic                  ovl_pend_q;
   logic [W-1:0]          mem_q [DEPTH];
   logic [PW-1:0]         wr_q;
   logic [PW-1:0]         rd_q;
   logic [PW:0]           fill_q;

   logic                  b;
   logic                  in_frame;
   logic                  stuff_slot;
   logic                  data_bit;
   logic                  lost;
   logic                  bit_e;
   logic                  stuff_e;
   logic                  form_e;
   logic                  ack_e;
   logic                  crc_e;
   logic                  err_go;
   logic                  sof;
   logic                  ovl_go;
   logic                  inter_ovl;
   logic                  push;
   logic                  full;
   logic                  pop;
   logic [2:0]            run_nx;
   logic [2:0]            flag_run;
   logic                  flag_lvl;

   // Saturating count of equal bus bits
   function automatic logic [2:0] run_step(input logic [2:0] r,
                                           input logic       same);
      logic [2:0] n;
      n = 3'h1;
      if (same)
      begin
         n = (r == 3'h7) ? 3'h7 : 3'(r + 3'h1);
      end
      return n;
   endfunction

   // Two-stage synchroniser on the bus pin
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_m_q <= cfpe_pkg::REC;
         rx_s_q <= cfpe_pkg::REC;
      end
      else
      begin
         rx_m_q <= rx_pin;
         rx_s_q <= rx_m_q;
      end
   end

   // Bit classification at the sample point
   assign b          = rx_s_q;
   assign in_frame   = (st_q == cfpe_pkg::ST_FRAME);
   assign stuff_slot = in_frame && (run_q == cfpe_pkg::STUFF_RUN);
   assign data_bit   = in_frame && !stuff_slot;
   assign run_nx     = run_step(run_q, b == last_q);
   assign flag_run   = run_step(run_q, (run_q != 3'h0) && (b == last_q));
   assign flag_lvl   = ovl_q ? cfpe_pkg::DOM : err_passive;  // [RQ25]
   // Recessive sent, dominant seen during arbitration: lost, no error
   assign lost = data_bit && txing_q && fr_arb
                 && tx_q == cfpe_pkg::REC && b == cfpe_pkg::DOM;  // [RQ13]

   // Error detection, one bit-time decision each
   assign bit_e = bit_tick && (tx_q != b)
                  && ((tx_q == cfpe_pkg::DOM) ? !stuff_slot
                      : (data_bit && txing_q && !fr_arb));  // [RQ18]
   assign stuff_e = bit_tick && stuff_slot && (b == last_q);  // [RQ19]
   assign form_e  = bit_tick && (b == cfpe_pkg::DOM)
                    && (st_q == cfpe_pkg::ST_CRC_DEL
                        || st_q == cfpe_pkg::ST_ACK_DEL
                        || st_q == cfpe_pkg::ST_EOF
                        || st_q == cfpe_pkg::ST_DELIM);  // [RQ21]
   assign ack_e   = bit_tick && (st_q == cfpe_pkg::ST_ACK) && txing_q
                    && (b == cfpe_pkg::REC);  // [RQ22]
   assign crc_e   = bit_tick && (st_q == cfpe_pkg::ST_ACK_DEL)
                    && crc_err_q && (b == cfpe_pkg::REC);  // [RQ20] [RQ24]
   assign err_go  = bit_e || stuff_e || form_e || ack_e || crc_e;  // [RQ24]

   // Dominant while idle, suspended or on the third intermission bit
   assign sof = bit_tick && !err_go && (b == cfpe_pkg::DOM)
                && (st_q == cfpe_pkg::ST_IDLE
                    || st_q == cfpe_pkg::ST_SUSPEND
                    || (st_q == cfpe_pkg::ST_INTER
                        && cnt_q == cfpe_pkg::SOF_SLOT));  // [RQ7] [RQ12]
   assign inter_ovl = bit_tick && !err_go && st_q == cfpe_pkg::ST_INTER
                      && b == cfpe_pkg::DOM
                      && cnt_q != cfpe_pkg::SOF_SLOT;  // [RQ11]
   assign ovl_go = bit_tick && !err_go && st_q == cfpe_pkg::ST_EOF
                   && cnt_q == cfpe_pkg::EOF_BITS - 4'h1 && !txing_q
                   && (ovl_pend_q || host_busy);  // [RQ10]

   // Next frame bit requested from the framer
   assign tx_take = bit_tick && !err_go
                    && ((sof && tx_q == cfpe_pkg::DOM)
                        || (data_bit && txing_q && !lost && !fr_crc_last
                            && run_nx != cfpe_pkg::STUFF_RUN)
                        || (stuff_slot && txing_q));  // [RQ15]
   assign bit_done = bit_tick && !err_go && data_bit;  // [RQ16]
   assign push     = bit_done;

   // Main protocol sequencer, one step per sample point outside sleep and stop
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q      <= cfpe_pkg::ST_IDLE;
         tx_q      <= cfpe_pkg::REC;
         run_q     <= cfpe_pkg::RUN_RST;
         last_q    <= cfpe_pkg::REC;
         cnt_q     <= cfpe_pkg::CNT_RST;
         txing_q   <= 1'b0;
         susp_q    <= 1'b0;
         crc_err_q <= 1'b0;
         ovl_q     <= 1'b0;
      end
      else if (st_q == cfpe_pkg::ST_SLEEP)
      begin
         if (cpu_access || b == cfpe_pkg::DOM)  // [RQ17]
         begin
            st_q <= cfpe_pkg::ST_IDLE;
         end
         else if (stop_req)
         begin
            st_q <= cfpe_pkg::ST_STOP;
         end
      end
      else if (st_q == cfpe_pkg::ST_STOP)
      begin
         if (cpu_access)  // [RQ17]
         begin
            st_q <= cfpe_pkg::ST_IDLE;
         end
      end
      else if (err_go)
      begin
         st_q    <= cfpe_pkg::ST_FLAG;  // [RQ24] [RQ4]
         ovl_q   <= 1'b0;
         tx_q    <= err_passive;  // [RQ25]
         run_q   <= cfpe_pkg::RUN_RST;
         susp_q  <= txing_q;
         txing_q <= 1'b0;
      end
      else if (sof)
      begin
         st_q    <= cfpe_pkg::ST_FRAME;
         txing_q <= (tx_q == cfpe_pkg::DOM);  // [RQ12] [RQ6]
         run_q   <= 3'h1;
         last_q  <= cfpe_pkg::DOM;
         tx_q    <= (tx_q == cfpe_pkg::DOM) ? tx_bit : cfpe_pkg::REC;
      end
      else if (inter_ovl || ovl_go)
      begin
         st_q  <= cfpe_pkg::ST_FLAG;  // [RQ10] [RQ11]
         ovl_q <= 1'b1;
         tx_q  <= cfpe_pkg::DOM;
         run_q <= cfpe_pkg::RUN_RST;
      end
      else if (bit_tick)
      begin
         case (st_q)
            cfpe_pkg::ST_IDLE:
            begin
               if (tx_req)
               begin
                  tx_q <= cfpe_pkg::DOM;  // [RQ5]
               end
               else if (sleep_req)
               begin
                  st_q <= cfpe_pkg::ST_SLEEP;
               end
            end
            cfpe_pkg::ST_FRAME:
            begin
               if (stuff_slot)
               begin
                  run_q  <= 3'h1;  // [RQ16]
                  last_q <= b;
                  tx_q   <= txing_q ? tx_bit : cfpe_pkg::REC;
               end
               else
               begin
                  run_q  <= run_nx;
                  last_q <= b;
                  if (lost)
                  begin
                     txing_q <= 1'b0;  // [RQ13] [RQ14]
                     tx_q    <= cfpe_pkg::REC;
                  end
                  else if (fr_crc_last)
                  begin
                     st_q      <= cfpe_pkg::ST_CRC_DEL;
                     tx_q      <= cfpe_pkg::REC;
                     crc_err_q <= !txing_q && !fr_crc_ok;
                  end
                  else if (txing_q && run_nx == cfpe_pkg::STUFF_RUN)
                  begin
                     tx_q <= ~b;  // [RQ15]
                  end
                  else
                  begin
                     tx_q <= txing_q ? tx_bit : cfpe_pkg::REC;
                  end
               end
            end
            cfpe_pkg::ST_CRC_DEL:
            begin
               st_q <= cfpe_pkg::ST_ACK;
               tx_q <= txing_q | crc_err_q;  // [RQ1] [RQ2]
            end
            cfpe_pkg::ST_ACK:
            begin
               st_q <= cfpe_pkg::ST_ACK_DEL;
               tx_q <= cfpe_pkg::REC;  // [RQ2]
            end
            cfpe_pkg::ST_ACK_DEL:
            begin
               st_q  <= cfpe_pkg::ST_EOF;
               cnt_q <= cfpe_pkg::CNT_RST;
            end
            cfpe_pkg::ST_EOF:
            begin
               if (cnt_q == cfpe_pkg::EOF_BITS - 4'h1)  // [RQ3]
               begin
                  st_q    <= cfpe_pkg::ST_INTER;  // [RQ4]
                  cnt_q   <= cfpe_pkg::CNT_RST;
                  susp_q  <= txing_q;
                  txing_q <= 1'b0;
               end
               else
               begin
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
            end
            cfpe_pkg::ST_INTER:
            begin
               if (cnt_q == cfpe_pkg::INTER_BITS - 4'h1)
               begin
                  cnt_q <= cfpe_pkg::CNT_RST;
                  if (susp_q && err_passive)
                  begin
                     st_q <= cfpe_pkg::ST_SUSPEND;  // [RQ6]
                  end
                  else
                  begin
                     st_q   <= cfpe_pkg::ST_IDLE;  // [RQ5]
                     susp_q <= 1'b0;
                  end
               end
               else
               begin
                  cnt_q <= 4'(cnt_q + 4'h1);
                  if (cnt_q == cfpe_pkg::TX_EARLY && tx_req
                      && !(susp_q && err_passive))
                  begin
                     tx_q <= cfpe_pkg::DOM;  // [RQ5] [RQ7]
                  end
               end
            end
            cfpe_pkg::ST_SUSPEND:
            begin
               if (cnt_q == cfpe_pkg::SUSP_BITS - 4'h1)
               begin
                  st_q   <= cfpe_pkg::ST_IDLE;  // [RQ6]
                  susp_q <= 1'b0;
               end
               else
               begin
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
            end
            cfpe_pkg::ST_FLAG:
            begin
               run_q  <= flag_run;
               last_q <= b;
               if (flag_run == cfpe_pkg::FLAG_BITS)  // [RQ8] [RQ25]
               begin
                  st_q <= cfpe_pkg::ST_FLAGW;
                  tx_q <= cfpe_pkg::REC;
               end
               else
               begin
                  tx_q <= flag_lvl;
               end
            end
            cfpe_pkg::ST_FLAGW:
            begin
               if (b == cfpe_pkg::REC)  // [RQ9]
               begin
                  st_q  <= cfpe_pkg::ST_DELIM;
                  cnt_q <= 4'h1;
               end
            end
            cfpe_pkg::ST_DELIM:
            begin
               if (cnt_q == cfpe_pkg::DELIM_BITS - 4'h1)
               begin
                  st_q  <= cfpe_pkg::ST_INTER;  // [RQ4]
                  cnt_q <= cfpe_pkg::CNT_RST;
               end
               else
               begin
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
            end
            default:
            begin
               st_q <= cfpe_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pending overload; a new overrun wins over the clear
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ovl_pend_q <= 1'b0;
      end
      else if (push && full)
      begin
         ovl_pend_q <= 1'b1;
      end
      else if (ovl_go)
      begin
         ovl_pend_q <= 1'b0;
      end
   end

   // Registered event pulses
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         arb_lost   <= 1'b0;
         frame_ok   <= 1'b0;
         err_bit    <= 1'b0;
         err_stuff  <= 1'b0;
         err_crc    <= 1'b0;
         err_form   <= 1'b0;
         err_ack    <= 1'b0;
         wake_evt   <= 1'b0;
         rx_overrun <= 1'b0;
      end
      else
      begin
         arb_lost   <= bit_tick && !err_go && lost;
         frame_ok   <= bit_tick && !err_go && st_q == cfpe_pkg::ST_EOF
                       && cnt_q == cfpe_pkg::EOF_BITS - 4'h1;
         err_bit    <= bit_e;
         err_stuff  <= stuff_e;
         err_crc    <= crc_e;
         err_form   <= form_e;
         err_ack    <= ack_e;
         wake_evt   <= st_q == cfpe_pkg::ST_SLEEP && !cpu_access
                       && b == cfpe_pkg::DOM;  // [RQ17]
         rx_overrun <= push && full;
      end
   end

   // Receive buffer between bus and framer
   assign full     = (fill_q == (PW + 1)'(DEPTH));
   assign rx_valid = (fill_q != '0);
   assign pop      = rx_valid && rx_ready;
   assign rx_data  = mem_q[rd_q];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q   <= '0;
         rd_q   <= '0;
         fill_q <= '0;
      end
      else
      begin
         if (push && !full)
         begin
            mem_q[wr_q] <= W'(b);
            wr_q        <= PW'(wr_q + 1'b1);
         end
         if (pop)
         begin
            rd_q <= PW'(rd_q + 1'b1);
         end
         if ((push && !full) && !pop)
         begin
            fill_q <= (PW + 1)'(fill_q + 1'b1);
         end
         else if (pop && !(push && !full))
         begin
            fill_q <= (PW + 1)'(fill_q - 1'b1);
         end
      end
   end

   // Status outputs
   assign tx_pin         = tx_q;  // [RQ23]
   assign is_transmitter = txing_q;
   assign bus_idle       = (st_q == cfpe_pkg::ST_IDLE);
   assign sleeping       = (st_q == cfpe_pkg::ST_SLEEP);
   assign stopped        = (st_q == cfpe_pkg::ST_STOP);
endmodule
`default_nettype wire

// File: tb/cfpe_props.sv
// Port checker for the frame protocol engine
`default_nettype none
module cfpe_props #(
   parameter int W = 1
) (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         bit_tick,
   input wire logic         tx_pin,
   input wire logic         tx_take,
   input wire logic         bit_done,
   input wire logic         rx_valid,
   input wire logic         rx_ready,
   input wire logic [W-1:0] rx_data,
   input wire logic         err_passive,
   input wire logic         cpu_access,
   input wire logic         stopped,
   input wire logic         frame_ok,
   input wire logic         err_bit,
   input wire logic         err_stuff,
   input wire logic         err_crc,
   input wire logic         err_form,
   input wire logic         err_ack,
   input wire logic         rx_overrun
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Drive level and framer strobes stay on the bit grid
   tx_hold_a: assert property (
      $changed(tx_pin) |-> $past(bit_tick))
      else $error("tx_pin moved off the bit grid");
   strobe_grid_a: assert property (
      (tx_take || bit_done) |-> bit_tick)
      else $error("framer strobe outside a bit tick");
   err_grid_a: assert property (
      (err_bit || err_stuff || err_form || err_ack || err_crc)
      |-> $past(bit_tick))
      else $error("error pulse not one clock after a tick");

   // Flag starts on the bit after detection, at the flag level
   flag_level_a: assert property (
      (err_bit || err_stuff || err_form || err_ack)
      |-> tx_pin == (err_passive ? cfpe_pkg::REC : cfpe_pkg::DOM))
      else $error("error flag level wrong");
   ack_slot_a: assert property (
      err_ack |-> $past(tx_pin) == cfpe_pkg::REC)
      else $error("ack error without recessive slot drive");
   eof_rec_a: assert property (
      frame_ok |-> $past(tx_pin) == cfpe_pkg::REC)
      else $error("frame closed on a dominant drive");

   // Receive buffer holds its word under a stall
   rx_hold_a: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("receive word lost under stall");
   ovr_push_a: assert property (
      rx_overrun |-> $past(bit_done))
      else $error("overrun without a refused push");
   stop_hold_a: assert property (
      stopped && !cpu_access |=> stopped)
      else $error("stop left without processor access");
endmodule
`default_nettype wire

// File: tb/cfpe_node_model.sv
// Other bus node: plays one level per bit time from a pattern
`default_nettype none
module cfpe_node_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        bit_tick,
   input  wire logic        go,
   input  wire logic [31:0] vec,
   output logic             drv,
   output logic             act,
   output logic [4:0]       idx
);
   timeunit 1ns;
   timeprecision 1ps;

   // New level right after a sample point, recessive once released
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         drv <= 1'b1;
         act <= 1'b0;
         idx <= 5'h00;
      end
      else if (bit_tick && go)
      begin
         act <= 1'b1;
         idx <= 5'h00;
         drv <= vec[0];
      end
      else if (bit_tick && act)
      begin
         act <= (idx != 5'h1F);
         idx <= idx + 5'h01;
         drv <= (idx == 5'h1F) ? 1'b1 : vec[idx + 5'h01];
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the frame protocol engine
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] FR  = 32'hFFFFCFA0; // Stuffed frame, idle tail
   localparam logic [11:0] DAT = 12'hBE0;      // Unstuffed frame bits
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        bit_tick = 1'b0;
   logic        tx_req = 1'b0;
   logic        tx_bit = 1'b1;
   logic        fr_arb = 1'b0, fr_crc_last = 1'b0, fr_crc_ok = 1'b0;
   logic        err_passive = 1'b0;
   logic        sleep_req = 1'b0, stop_req = 1'b0, cpu_access = 1'b0;
   logic        rx_ready = 1'b0, go = 1'b0;
   logic [31:0] vec = 32'hFFFFFFFF, seen;
   logic [11:0] rxw;
   logic [2:0]  cyc = 3'h0;
   logic [4:0]  idx;
   logic [0:0]  rx_data;
   logic        drv, act, bus, tx_pin, tx_take, bit_done, rx_valid;
   logic        bus_idle, sleeping, stopped, frame_ok, err_bit, err_stuff;
   logic        err_crc, err_form, err_ack, wake_evt, rx_overrun, arb_lost;
   int          tp, rp;
   int          n [7]; // ok, other errors, crc, ack, overrun, wake, lost
   int          bad_count = 0, num_checks = 0;

   always #12.5 clk = ~clk;
   assign bus = tx_pin & drv;

   cfpe_engine #(.DEPTH(2), .W(1)) cfpe_engine_inst (
      .clk(clk), .rst(rst), .bit_tick(bit_tick), .rx_pin(bus),
      .tx_pin(tx_pin), .tx_req(tx_req), .tx_bit(tx_bit),
      .tx_take(tx_take), .fr_arb(fr_arb), .fr_crc_last(fr_crc_last),
      .fr_crc_ok(fr_crc_ok), .err_passive(err_passive),
      .host_busy(1'b0), .sleep_req(sleep_req), .stop_req(stop_req),
      .cpu_access(cpu_access), .bit_done(bit_done), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .is_transmitter(),
      .bus_idle(bus_idle), .sleeping(sleeping), .stopped(stopped),
      .arb_lost(arb_lost), .frame_ok(frame_ok), .err_bit(err_bit),
      .err_stuff(err_stuff), .err_crc(err_crc), .err_form(err_form),
      .err_ack(err_ack), .wake_evt(wake_evt), .rx_overrun(rx_overrun));

   cfpe_node_model cfpe_node_model_inst (
      .clk(clk), .rst(rst), .bit_tick(bit_tick), .go(go), .vec(vec),
      .drv(drv), .act(act), .idx(idx));

   // Sample-point strobe every eighth clock
   always @(negedge clk)
   begin
      cyc <= cyc + 3'h1;
      bit_tick <= (cyc == 3'h7) && !rst;
      tx_bit <= (tp < 12) ? DAT[tp] : 1'b1;
      fr_arb <= (rp < 6);
      fr_crc_last <= (rp == 11);
   end

   // Framer pointers, drive record, popped words, pulse tallies
   always @(posedge clk)
   begin
      if (tx_take) tp <= tp + 1;
      if (bit_done) rp <= rp + 1;
      if (act && bit_tick) seen[idx] <= tx_pin;
      if (rx_valid && rx_ready) rxw <= {rx_data, rxw[11:1]};
      if (frame_ok || err_ack) tx_req <= 1'b0;
      if (frame_ok) n[0] <= n[0] + 1;
      if (err_bit || err_stuff || err_form) n[1] <= n[1] + 1;
      if (err_crc) n[2] <= n[2] + 1;
      if (err_ack) n[3] <= n[3] + 1;
      if (rx_overrun) n[4] <= n[4] + 1;
      if (wake_evt) n[5] <= n[5] + 1;
      if (arb_lost) n[6] <= n[6] + 1;
   end

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic launch(logic [31:0] v, logic req, logic ok, logic pas);
      n = '{default: 0};
      tp = 0;
      rp = 0;
      rxw = '1;
      do @(posedge clk); while (cyc != 3'h7);
      @(negedge clk);
      vec <= v;
      tx_req <= req;
      fr_crc_ok <= ok;
      err_passive <= pas;
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      repeat (300) @(negedge clk);
   endtask

   task automatic wait_idle;
      int k = 0;
      while (bus_idle !== 1'b1 && k < 4000)
      begin
         @(negedge clk);
         k++;
      end
      chk("idle", 1, bus_idle);
   endtask

   task automatic t_tx_ack;
      launch(32'hFFFEFFFF, 1'b1, 1'b1, 1'b0);
      chk("tx bits", FR, seen);
      chk("frame ok", 1, n[0]);
      chk("errors", 0, n[1] + n[3]);
   endtask

   task automatic t_arb;
      wait_idle;
      launch(32'hFFFFCF20, 1'b1, 1'b1, 1'b0);
      chk("arb lost", 1, n[6]);
      chk("lost drive", 32'hFFFF7FA0, seen);
   endtask

   task automatic t_ack_err;
      wait_idle;
      launch(32'hFFFFFFFF, 1'b1, 1'b1, 1'b1);
      chk("ack error", 1, n[3]);
      chk("passive bits", FR, seen);
      chk("frame ok", 0, n[0]);
   endtask

   task automatic t_rx_crc;
      wait_idle;
      launch(FR, 1'b0, 1'b0, 1'b0);
      chk("crc error", 1, n[2]);
      chk("ack slot", 1, seen[16]);
      chk("flag", 0, seen[23:18]);
      chk("rx words", DAT, rxw);
   endtask

   task automatic t_overload;
      wait_idle;
      rx_ready <= 1'b0;
      launch(FR, 1'b0, 1'b1, 1'b0);
      chk("ack slot", 0, seen[16]);
      chk("overrun", 1, n[4] != 0);
      chk("overload", 0, seen[30:25]);
      rx_ready <= 1'b1;
      repeat (3) @(negedge clk);
      chk("kept words", {DAT[1], DAT[0]}, rxw[11:10]);
      chk("drained", 0, rx_valid);
   endtask

   task automatic t_sleep;
      wait_idle;
      sleep_req <= 1'b1;
      repeat (40) @(negedge clk);
      chk("sleeping", 1, sleeping);
      sleep_req <= 1'b0;
      launch(32'hFFFFFFFE, 1'b0, 1'b0, 1'b0);
      chk("wake", 1, n[5]);
      chk("awake", 0, sleeping);
      {sleep_req, stop_req} <= 2'h3;
      repeat (40) @(negedge clk);
      chk("stopped", 1, stopped);
      {sleep_req, stop_req} <= 2'h0;
      launch(32'hFFFFFFFE, 1'b0, 1'b0, 1'b0);
      chk("still stopped", 1, stopped);
      cpu_access <= 1'b1;
      @(negedge clk);
      cpu_access <= 1'b0;
      repeat (40) @(negedge clk);
      chk("released", 0, stopped);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence after a five-cycle reset
   initial
   begin
      repeat (5) @(negedge clk);
      rst <= 1'b0;
      rx_ready <= 1'b1;
      repeat (4) @(negedge clk);
      chk("tx idle", 1, tx_pin);
      chk("rx empty", 0, rx_valid);
      t_tx_ack;
      t_arb;
      t_ack_err;
      t_rx_crc;
      t_overload;
      t_sleep;
      report_and_stop;
   end

   // Watchdog well beyond the few thousand clocks the run needs
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
endmodule

bind cfpe_engine cfpe_props #(.W(W)) cfpe_props_inst (
   .clk(clk), .rst(rst), .bit_tick(bit_tick), .tx_pin(tx_pin),
   .tx_take(tx_take), .bit_done(bit_done), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .rx_data(rx_data), .err_passive(err_passive),
   .cpu_access(cpu_access), .stopped(stopped), .frame_ok(frame_ok),
   .err_bit(err_bit), .err_stuff(err_stuff), .err_crc(err_crc),
   .err_form(err_form), .err_ack(err_ack), .rx_overrun(rx_overrun));
`default_nettype wire
